// ### rtl/pse_pkg.sv
// Package for the packet sink error checker: register map, fields, timing and carriers
package pse_pkg;
   // APB register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h04;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
   localparam logic [7:0] ADDR_CAUSE = 8'h0c;
   localparam logic [7:0] ADDR_LINK = 8'h10;
   // Reset values
   localparam logic [31:0] CTRL_RST = 32'h0000_0001;
   localparam logic [3:0] IRQ_MASK_RST = 4'h0;
   // Control register field
   localparam int CTRL_EN = 0;
   // Interrupt status bits
   localparam int IRQ_PROTO = 0;
   localparam int IRQ_LOST = 1;
   localparam int IRQ_BURST = 2;
   localparam int IRQ_PARITY = 3;
   localparam int IRQ_W = 4;
   // Link status fields
   localparam int LINK_LOCKED = 0;
   localparam int LINK_LOST = 1;
   // Protocol error cause positions
   localparam int CB_SOP_SPACE = 0;
   localparam int CB_EOP_NO_DATA = 1;
   localparam int CB_PAY_NO_DATA = 2;
   localparam int CB_IDLE_DIP = 3;
   localparam int CB_RESERVED = 4;
   localparam int CB_ADDR_NO_PAY = 5;
   // Control word fields
   localparam int CW_PAY = 15;
   localparam int CW_EOPS_HI = 14;
   localparam int CW_EOPS_LO = 13;
   localparam int CW_SOP = 12;
   localparam int CW_ADDR_HI = 11;
   localparam int CW_ADDR_LO = 4;
   localparam logic [1:0] EOPS_NONE = 2'h0;
   localparam logic [1:0] EOPS_ABORT = 2'h1;
   localparam logic [11:0] TRAIN_HI = 12'h0ff;
   // Protocol counts
   localparam int SOP_MIN_GAP = 8;
   localparam int CREDIT_WORDS = 8;
   localparam int LOCK_EDGES = 16;
   // Clock-loss timeout: least time, rounded up
   localparam int CLK_PERIOD_NS = 25;
   localparam int LOST_TIME_NS = 1000;
   localparam int LOST_CYC = (LOST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // One sampled link word
   typedef struct packed {
      logic ctl;
      logic [15:0] dat;
   } pse_word_s;

   // One tagged word toward the user FIFO
   typedef struct packed {
      logic sop;
      logic eop;
      logic abort;
      logic burst_err;
      logic end_par;
      logic start_par;
      logic bad_pay;
      logic [7:0] addr;
      logic [15:0] dat;
   } pse_tag_s;
endpackage : pse_pkg

// ### rtl/pse_checker.sv
// Receive-side protocol checker and packet tagger with APB registers
//
// Behaviour
// - Start-of-packet words under eight words apart pass data but flag protocol error.
// - Burst ending off credit boundary without end gets burst error, no end markers.
// - End-of-packet abort sets end and abort markers, never burst error.
// - Clock lost shown while link clock absent; lock low or dropped then.
// - Eight-bit cause vector accompanies the protocol error flag in the same cycle.
// - Cause bits: 0 sop spacing, 1 eop without data, 2 payload without data.
// - Cause bit 3 parity error on idle/training; bit 4 reserved word.
// - Cause bit 5 non-payload non-training word with address; bits 7:6 zero.
// - Back-to-back payload words: keep last, flag each discarded one.
// - Back-to-back end words: keep first after data, drop others, flag error.
// - Any set cause bit also raises the protocol error flag.
// - Parity error on burst-ending word tags terminated packet with end parity.
// - Parity error on payload word tags next burst with start parity.
// - Both parity flags appear at the end of the affected burst.
// - Start without payload bit followed by data: bad payload whole burst, flag.
// - Such reserved word not followed by data is dropped and flagged.
`timescale 1ns/10ps
module pse_checker import pse_pkg::*; #(
   parameter int SOP_GAP = SOP_MIN_GAP, // Least start-of-packet spacing in words
   parameter int CREDIT = CREDIT_WORDS  // Words per credit boundary
) (
   input wire logic pclk,                          // System clock, 40 MHz
   input wire logic presetn,                       // Asynchronous reset, active low
   input wire logic psel,                          // APB select
   input wire logic penable,                       // APB access phase
   input wire logic pwrite,                        // APB write
   input wire logic [7:0] paddr,                   // APB byte address
   input wire logic [31:0] pwdata,                 // APB write data
   output logic [31:0] prdata,                     // APB read data
   output logic pready,                            // APB ready
   output logic pslverr,                           // APB error on unmapped address
   input wire logic rx_data_clock,                 // Link data clock pin
   input wire logic rx_ctl,                        // Link control flag pin
   input wire logic [15:0] rx_data_bus,            // Link data pins
   output logic user_valid,                        // Tagged word strobe
   output logic [15:0] user_data,                  // Tagged word data
   output logic [7:0] user_addr,                   // Channel address
   output logic user_sop,                          // First word of packet
   output logic packet_end_marker,                 // Last word of packet
   output logic packet_abort_marker,               // Packet aborted
   output logic burst_termination_error,           // Burst ended badly
   output logic end_parity_error,                  // Parity error on ending word
   output logic start_parity_error,                // Parity error on payload word
   output logic bad_payload_word_error,            // Burst had reserved start word
   output logic protocol_error_flag,               // Bus-level violation pulse
   output logic [7:0] protocol_error_cause,        // Violation cause pulse
   output logic rx_clock_lost,                     // Link clock absent
   output logic rx_clock_locked,                   // Link clock stable
   output logic irq                                // Interrupt, level
);
   localparam int GW = $clog2(SOP_GAP + 1);
   localparam int CW = $clog2(CREDIT + 1);
   localparam int LW = $clog2(LOST_CYC + 1);
   localparam int EW = $clog2(LOCK_EDGES + 1);

   // Pin synchronisers: stage one is read only by stage two
   logic [16:0] sy1_q, sy2_q;
   logic clk1_q, clk2_q, clk3_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sy1_q <= '0;
         sy2_q <= '0;
         clk1_q <= 1'b0;
         clk2_q <= 1'b0;
         clk3_q <= 1'b0;
      end else begin
         sy1_q <= {rx_ctl, rx_data_bus};
         sy2_q <= sy1_q;
         clk1_q <= rx_data_clock;
         clk2_q <= clk1_q;
         clk3_q <= clk2_q;
      end
   end

   pse_word_s w;
   logic edge_s;
   assign w = sy2_q;
   assign edge_s = clk2_q & ~clk3_q;

   // Clock monitor: loss by silence timeout, lock after steady edges
   logic [LW-1:0] sil_q, sil_d;
   logic [EW-1:0] ecnt_q, ecnt_d;
   logic lost_q, lost_d, lock_q, lock_d;
   always_comb begin
      sil_d = sil_q;
      ecnt_d = ecnt_q;
      lost_d = lost_q;
      lock_d = lock_q;
      if (edge_s) begin
         sil_d = '0;
         lost_d = 1'b0;
         if (ecnt_q != EW'(LOCK_EDGES)) ecnt_d = ecnt_q + 1'b1;
         else lock_d = 1'b1;
      end else if (sil_q == LW'(LOST_CYC)) begin
         lost_d = 1'b1;
         lock_d = 1'b0;
         ecnt_d = '0;
      end else begin
         sil_d = sil_q + 1'b1;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sil_q <= '0;
         ecnt_q <= '0;
         lost_q <= 1'b1;                      // Absent until edges seen
         lock_q <= 1'b0;
      end else begin
         sil_q <= sil_d;
         ecnt_q <= ecnt_d;
         lost_q <= lost_d;
         lock_q <= lock_d;
      end
   end

   logic [31:0] ctrl_q, ctrl_d;
   logic lw;
   // Words are processed only once locked, so no sync is ever reached without a clock
   assign lw = edge_s & lock_q & ctrl_q[CTRL_EN];

   // Datapath state; the held word waits for the next link word to learn its end flags
   pse_tag_s held_q, held_d, out_q, out_d;
   logic held_v_q, held_v_d, out_v_q, out_v_d;
   logic in_burst_q, in_burst_d, pend_q, pend_d;
   logic pend_sop_q, pend_sop_d, pend_bad_q, pend_bad_d, pend_par_q, pend_par_d;
   logic [7:0] pend_addr_q, pend_addr_d;
   logic b_bad_q, b_bad_d, b_spar_q, b_spar_d;
   logic [7:0] b_addr_q, b_addr_d;
   logic [CW-1:0] wcnt_q, wcnt_d;
   logic [GW-1:0] gap_q, gap_d;
   logic [15:0] acc_q, acc_d;
   logic [7:0] cause_q, cause_d;
   logic err_q, err_d;

   logic is_pay, sop, rsvd, par_err;
   logic [1:0] eops;
   logic [7:0] addr;
   logic [15:0] fold;
   always_comb begin
      is_pay = w.dat[CW_PAY];
      sop = w.dat[CW_SOP];
      eops = w.dat[CW_EOPS_HI:CW_EOPS_LO];
      addr = w.dat[CW_ADDR_HI:CW_ADDR_LO];
      rsvd = ~is_pay & sop;
      // Parity over the words since the last control word and this one, nibble folded
      fold = acc_q ^ {w.dat[15:4], 4'hf};
      par_err = (fold[15:12] ^ fold[11:8] ^ fold[7:4] ^ fold[3:0]) != w.dat[3:0];
   end

   // Sequencing of control and data words
   always_comb begin
      held_d = held_q;
      held_v_d = held_v_q;
      out_d = out_q;
      out_v_d = 1'b0;
      in_burst_d = in_burst_q;
      pend_d = pend_q;
      pend_sop_d = pend_sop_q;
      pend_bad_d = pend_bad_q;
      pend_par_d = pend_par_q;
      pend_addr_d = pend_addr_q;
      b_bad_d = b_bad_q;
      b_spar_d = b_spar_q;
      b_addr_d = b_addr_q;
      wcnt_d = wcnt_q;
      gap_d = gap_q;
      acc_d = acc_q;
      cause_d = '0;
      err_d = 1'b0;
      if (lw) begin
         if (gap_q != GW'(SOP_GAP)) gap_d = gap_q + 1'b1;
         if (!w.ctl) begin
            acc_d = acc_q ^ w.dat;
            wcnt_d = (wcnt_q == CW'(CREDIT - 1)) ? '0 : wcnt_q + 1'b1;
            if (in_burst_q) begin
               out_d = held_q;
               out_v_d = held_v_q;
               held_d = '{sop: 1'b0, eop: 1'b0, abort: 1'b0, burst_err: 1'b0,
                          end_par: 1'b0, start_par: 1'b0, bad_pay: b_bad_q,
                          addr: b_addr_q, dat: w.dat};
               held_v_d = 1'b1;
            end else if (pend_q) begin
               // Last payload word before data is the one kept
               held_d = '{sop: pend_sop_q, eop: 1'b0, abort: 1'b0, burst_err: 1'b0,
                          end_par: 1'b0, start_par: 1'b0, bad_pay: pend_bad_q,
                          addr: pend_addr_q, dat: w.dat};
               held_v_d = 1'b1;
               b_bad_d = pend_bad_q;
               b_spar_d = pend_par_q;
               b_addr_d = pend_addr_q;
               in_burst_d = 1'b1;
               pend_d = 1'b0;
               wcnt_d = CW'(1 % CREDIT);
            end
         end else begin
            acc_d = '0;
            if (in_burst_q) begin
               // Burst ends here; flags ride on its last word
               out_d = held_q;
               out_v_d = held_v_q;
               out_d.eop = eops != EOPS_NONE;
               out_d.abort = eops == EOPS_ABORT;
               out_d.burst_err = eops == EOPS_NONE && wcnt_q != '0;
               out_d.end_par = par_err;
               out_d.start_par = b_spar_q;
               held_v_d = 1'b0;
               in_burst_d = 1'b0;
            end else begin
               cause_d[CB_EOP_NO_DATA] = eops != EOPS_NONE;
               cause_d[CB_IDLE_DIP] = par_err & ~is_pay;
            end
            // A pending payload word meeting another control word is discarded
            cause_d[CB_PAY_NO_DATA] = pend_q & ~pend_bad_q;
            cause_d[CB_RESERVED] = rsvd;
            cause_d[CB_ADDR_NO_PAY] = ~is_pay & ~sop & addr != 8'h00
                                      & w.dat[15:4] != TRAIN_HI;
            pend_d = is_pay | rsvd;
            pend_sop_d = sop;
            pend_bad_d = rsvd;
            pend_par_d = par_err & is_pay;
            pend_addr_d = addr;
            if (sop) begin
               cause_d[CB_SOP_SPACE] = (gap_q + 1'b1) < GW'(SOP_GAP);
               gap_d = '0;
            end
         end
         err_d = |cause_d;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         held_q <= '0;
         held_v_q <= 1'b0;
         out_q <= '0;
         out_v_q <= 1'b0;
         in_burst_q <= 1'b0;
         pend_q <= 1'b0;
         pend_sop_q <= 1'b0;
         pend_bad_q <= 1'b0;
         pend_par_q <= 1'b0;
         pend_addr_q <= 8'h00;
         b_bad_q <= 1'b0;
         b_spar_q <= 1'b0;
         b_addr_q <= 8'h00;
         wcnt_q <= '0;
         gap_q <= GW'(SOP_GAP);
         acc_q <= 16'h0000;
         cause_q <= 8'h00;
         err_q <= 1'b0;
      end else begin
         held_q <= held_d;
         held_v_q <= held_v_d;
         out_q <= out_d;
         out_v_q <= out_v_d;
         in_burst_q <= in_burst_d;
         pend_q <= pend_d;
         pend_sop_q <= pend_sop_d;
         pend_bad_q <= pend_bad_d;
         pend_par_q <= pend_par_d;
         pend_addr_q <= pend_addr_d;
         b_bad_q <= b_bad_d;
         b_spar_q <= b_spar_d;
         b_addr_q <= b_addr_d;
         wcnt_q <= wcnt_d;
         gap_q <= gap_d;
         acc_q <= acc_d;
         cause_q <= cause_d;
         err_q <= err_d;
      end
   end

   // User side outputs
   assign user_valid = out_v_q;
   assign user_data = out_q.dat;
   assign user_addr = out_q.addr;
   assign user_sop = out_q.sop;
   assign packet_end_marker = out_q.eop;
   assign packet_abort_marker = out_q.abort;
   assign burst_termination_error = out_q.burst_err;
   assign end_parity_error = out_q.end_par;
   assign start_parity_error = out_q.start_par;
   assign bad_payload_word_error = out_q.bad_pay;
   assign protocol_error_flag = err_q;
   assign protocol_error_cause = cause_q;
   assign rx_clock_lost = lost_q;
   assign rx_clock_locked = lock_q;

   // Register file and interrupt; a new event wins over a same-cycle clear
   logic [IRQ_W-1:0] stat_q, stat_d, mask_q, mask_d, ev;
   logic [7:0] acc_cause_q, acc_cause_d;
   logic lost_dly_q;
   logic wr, rd_ok;
   assign wr = psel & penable & pwrite;
   always_comb begin
      ev = '0;
      ev[IRQ_PROTO] = err_q;
      ev[IRQ_LOST] = lost_q & ~lost_dly_q;
      ev[IRQ_BURST] = out_v_q & out_q.burst_err;
      ev[IRQ_PARITY] = out_v_q & (out_q.end_par | out_q.start_par);
      ctrl_d = ctrl_q;
      mask_d = mask_q;
      stat_d = stat_q;
      acc_cause_d = acc_cause_q;
      rd_ok = 1'b1;
      prdata = 32'h0000_0000;
      unique case (paddr)
         ADDR_CTRL: prdata = ctrl_q;
         ADDR_IRQ_STAT: prdata[IRQ_W-1:0] = stat_q;
         ADDR_IRQ_MASK: prdata[IRQ_W-1:0] = mask_q;
         ADDR_CAUSE: prdata[7:0] = acc_cause_q;
         ADDR_LINK: prdata[LINK_LOST:LINK_LOCKED] = {lost_q, lock_q};
         default: rd_ok = 1'b0;
      endcase
      if (wr) begin
         if (paddr == ADDR_CTRL) ctrl_d = {31'h0, pwdata[CTRL_EN]};
         if (paddr == ADDR_IRQ_MASK) mask_d = pwdata[IRQ_W-1:0];
         if (paddr == ADDR_IRQ_STAT) stat_d = stat_q & ~pwdata[IRQ_W-1:0];
         if (paddr == ADDR_CAUSE) acc_cause_d = acc_cause_q & ~pwdata[7:0];
      end
      stat_d = stat_d | ev;
      acc_cause_d = acc_cause_d | cause_q;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= CTRL_RST;
         mask_q <= IRQ_MASK_RST;
         stat_q <= '0;
         acc_cause_q <= 8'h00;
         lost_dly_q <= 1'b1;
      end else begin
         ctrl_q <= ctrl_d;
         mask_q <= mask_d;
         stat_q <= stat_d;
         acc_cause_q <= acc_cause_d;
         lost_dly_q <= lost_q;
      end
   end
   assign pready = 1'b1;                       // Zero-wait slave
   assign pslverr = psel & penable & ~rd_ok;
   assign irq = |(stat_q & mask_q);
endmodule : pse_checker

// ### test/pse_checker_assertions.sv
// Port-level checks for the packet sink error checker
`timescale 1ns/10ps
module pse_checker_sva import pse_pkg::*; (
   input wire logic pclk, // System clock
   input wire logic presetn, // Reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB access
   input wire logic [7:0] paddr, // APB address
   input wire logic [31:0] prdata, // APB read data
   input wire logic pslverr, // APB error
   input wire logic rx_data_clock, // Link clock pin
   input wire logic user_valid, // Word strobe
   input wire logic packet_end_marker, // Packet end
   input wire logic packet_abort_marker, // Packet abort
   input wire logic burst_termination_error, // Burst error
   input wire logic protocol_error_flag, // Violation pulse
   input wire logic [7:0] protocol_error_cause, // Violation cause
   input wire logic rx_clock_lost, // Clock lost
   input wire logic rx_clock_locked // Clock locked
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic lk_q, lk_d;
   logic [7:0] quiet_q, quiet_d;
   // Cycles since the pin last rose; saturates so a long stop never wraps
   always_comb begin
      lk_d = rx_data_clock;
      quiet_d = (rx_data_clock && !lk_q) ? 8'h00 : quiet_q + {7'h0, quiet_q != 8'hff};
   end
   // Counter registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lk_q <= 1'b0;
         quiet_q <= 8'h00;
      end else begin
         lk_q <= lk_d;
         quiet_q <= quiet_d;
      end
   end
   sequence s_abort_end; user_valid && packet_abort_marker; endsequence
   sequence s_burst_bad; user_valid && burst_termination_error; endsequence
   property p_flag_cause; protocol_error_flag == (|protocol_error_cause); endproperty
   property p_cause_res; protocol_error_cause[7:6] == 2'h0; endproperty
   property p_flag_pulse; protocol_error_flag |=> !protocol_error_flag; endproperty
   property p_abort; s_abort_end |-> packet_end_marker && !burst_termination_error; endproperty
   property p_burst; s_burst_bad |-> !packet_end_marker && !packet_abort_marker; endproperty
   property p_lost_lock; rx_clock_lost |-> !rx_clock_locked; endproperty
   property p_lost_time; quiet_q > LOST_CYC + 6 |-> rx_clock_lost; endproperty
   property p_unmapped; psel && penable && paddr > 8'h10 |-> pslverr && prdata == 32'h0;
   endproperty
   property p_mapped; psel && penable && paddr[1:0] == 2'h0 && paddr <= 8'h10 |-> !pslverr;
   endproperty
   a_flag_cause: assert property (p_flag_cause) else $error("flag and cause disagree");
   a_cause_res: assert property (p_cause_res) else $error("reserved cause bits set");
   a_flag_pulse: assert property (p_flag_pulse) else $error("flag longer than one");
   a_abort: assert property (p_abort) else $error("abort without end marker");
   a_burst: assert property (p_burst) else $error("burst error with end marker");
   a_lost_lock: assert property (p_lost_lock) else $error("locked while lost");
   a_lost_time: assert property (p_lost_time) else $error("stopped clock not lost");
   a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
   a_mapped: assert property (p_mapped) else $error("mapped access refused");
endmodule : pse_checker_sva

bind pse_checker pse_checker_sva u_pse_checker_sva (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
   .rx_data_clock(rx_data_clock), .user_valid(user_valid),
   .packet_end_marker(packet_end_marker), .packet_abort_marker(packet_abort_marker),
   .burst_termination_error(burst_termination_error),
   .protocol_error_flag(protocol_error_flag), .protocol_error_cause(protocol_error_cause),
   .rx_clock_lost(rx_clock_lost), .rx_clock_locked(rx_clock_locked));

// ### test/pse_link_src.sv
// Behavioural link source: control and data words with their parity nibble
`timescale 1ns/10ps
module pse_link_src (
   output logic rx_data_clock, // Link clock, still between words
   output logic rx_ctl, // Control flag
   output logic [15:0] rx_data_bus // Link word
);
   logic [15:0] acc;
   // Idle state at time zero
   initial begin
      rx_data_clock = 1'b0;
      rx_ctl = 1'b1;
      rx_data_bus = 16'h000f;
      acc = 16'h0000;
   end
   // One word per 200 ns; a control word closes the parity span
   task send(input logic c, input logic [15:0] d, input logic bad);
      logic [15:0] x;
      x = acc ^ {d[15:4], 4'hf};
      rx_ctl = c;
      rx_data_bus = c ? {d[15:4], x[15:12] ^ x[11:8] ^ x[7:4] ^ x[3:0] ^ {3'h0, bad}} : d;
      acc = c ? 16'h0000 : acc ^ d;
      #100 rx_data_clock = 1'b1;
      // Hold time over: show the inverse so a late sample cannot pass
      #50 rx_data_bus = ~rx_data_bus;
      rx_ctl = ~rx_ctl;
      #50 rx_data_clock = 1'b0;
   endtask : send
endmodule : pse_link_src

// ### test/test_pse_checker.sv
// Self-checking bench for the packet sink error checker
`timescale 1ns/10ps
module test_pse_checker import pse_pkg::*;;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_data_clock, rx_ctl;
   logic [7:0] paddr, user_addr, protocol_error_cause, naddr;
   logic [31:0] pwdata, prdata, rdv;
   logic [15:0] rx_data_bus, user_data;
   logic user_valid, user_sop, packet_end_marker, packet_abort_marker, end_parity_error;
   logic burst_termination_error, start_parity_error, bad_payload_word_error;
   logic protocol_error_flag, rx_clock_lost, rx_clock_locked, irq, err, pv, nsop, bp;
   int n_fail = 0, n_compared = 0, seed = 32'h7eeb;
   pse_tag_s eq[$], mq[$], pend, msk, got, e, m;
   logic [7:0] cq[$];

   pse_checker u_pse_checker (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_data_clock(rx_data_clock), .rx_ctl(rx_ctl),
      .rx_data_bus(rx_data_bus), .user_valid(user_valid), .user_data(user_data),
      .user_addr(user_addr), .user_sop(user_sop), .packet_end_marker(packet_end_marker),
      .packet_abort_marker(packet_abort_marker), .end_parity_error(end_parity_error),
      .burst_termination_error(burst_termination_error), .irq(irq),
      .start_parity_error(start_parity_error), .bad_payload_word_error(bad_payload_word_error),
      .protocol_error_flag(protocol_error_flag), .protocol_error_cause(protocol_error_cause),
      .rx_clock_lost(rx_clock_lost), .rx_clock_locked(rx_clock_locked));
   pse_link_src u_pse_link_src (.rx_data_clock(rx_data_clock), .rx_ctl(rx_ctl),
      .rx_data_bus(rx_data_bus));

   // 40 MHz clock
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      n_compared++;
      if (g !== x) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, x, g);
      end
   endtask : chk

   task give_verdict();
      $display("compared %0d mismatched %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : give_verdict

   // One APB transfer; waits for pready under a bound
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      chk("ready", 32'h1, {31'h0, pready});
      rdv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk("read data", x, rdv);
   endtask : rd

   // Control word; fl tags the word it ends: eop, abort, burst, end par, start par
   task cw(input logic [11:0] u, input logic [4:0] fl, input logic [7:0] c, input logic bad);
      if (pv) begin
         {pend.eop, pend.abort, pend.burst_err, pend.end_par, pend.start_par} = fl;
         eq.push_back(pend);
         mq.push_back(msk);
         pv = 1'b0;
      end
      if (c != 8'h00) cq.push_back(c);
      nsop = u[8];
      naddr = u[7:0];
      u_pse_link_src.send(1'b1, {u, 4'h0}, bad);
   endtask : cw

   // Random data word; its tags are noted once the next word settles them
   task dw();
      if (pv) begin
         eq.push_back(pend);
         mq.push_back(msk);
      end
      pend = '0;
      pend.sop = nsop;
      pend.bad_pay = bp;
      pend.addr = naddr;
      pend.dat = 16'($random(seed));
      pv = 1'b1;
      nsop = 1'b0;
      u_pse_link_src.send(1'b0, pend.dat, 1'b0);
   endtask : dw

   task idle(input int n);
      repeat (n) cw(12'h000, 5'h00, 8'h00, 1'b0);
   endtask : idle

   task fin(input string s);
      $display("test %s done", s);
   endtask : fin

   // Oldest note against each result as it appears
   always @(posedge pclk) begin
      if (user_valid === 1'b1) begin
         got = {user_sop, packet_end_marker, packet_abort_marker, burst_termination_error,
            end_parity_error, start_parity_error, bad_payload_word_error, user_addr, user_data};
         if (eq.size() == 0) chk("spare word", 32'h0, 32'h1);
         else begin
            e = eq.pop_front();
            m = mq.pop_front();
            chk("tagged word", {1'b0, e & m}, {1'b0, got & m});
         end
      end
      if (protocol_error_flag === 1'b1) begin
         if (cq.size() == 0) chk("spare cause", 32'h0, {24'h0, protocol_error_cause});
         else chk("cause", {24'h0, cq.pop_front()}, {24'h0, protocol_error_cause});
      end
   end

   // Watchdog, well beyond the 30 us the sequence needs
   initial begin
      #300000;
      chk("watchdog", 32'h0, 32'h1);
      give_verdict();
   end

   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, pv, nsop, naddr, bp} = '0;
      msk = '1;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(ADDR_CTRL, CTRL_RST);
      rd(ADDR_IRQ_MASK, 32'h0);
      rd(ADDR_LINK, 32'h2);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, err});
      fin("reset");
      #13 idle(20);
      rd(ADDR_LINK, 32'h1);
      apb(1'b1, ADDR_IRQ_STAT, 32'hf);
      #13 cw(12'h901, 5'h00, 8'h00, 1'b0);
      dw();
      dw();
      cw(12'hd02, 5'h10, 8'h01, 1'b0);
      dw();
      dw();
      cw(12'h400, 5'h10, 8'h00, 1'b0);
      idle(8);
      rd(ADDR_CAUSE, 32'h1);
      chk("irq masked", 32'h0, {31'h0, irq});
      apb(1'b1, ADDR_IRQ_MASK, 32'h1);
      rd(ADDR_IRQ_STAT, 32'h1);
      chk("irq raised", 32'h1, {31'h0, irq});
      apb(1'b1, ADDR_IRQ_STAT, 32'h1);
      rd(ADDR_IRQ_STAT, 32'h0);
      chk("irq cleared", 32'h0, {31'h0, irq});
      fin("spacing and interrupt");
      #13 cw(12'h903, 5'h00, 8'h00, 1'b0);
      repeat (3) dw();
      cw(12'h803, 5'h04, 8'h00, 1'b0);
      dw();
      cw(12'h400, 5'h10, 8'h00, 1'b0);
      idle(8);
      cw(12'h904, 5'h00, 8'h00, 1'b0);
      dw();
      dw();
      cw(12'h200, 5'h18, 8'h00, 1'b0);
      idle(8);
      cw(12'h805, 5'h00, 8'h04, 1'b0);
      cw(12'h807, 5'h00, 8'h04, 1'b0);
      cw(12'h906, 5'h00, 8'h00, 1'b0);
      dw();
      dw();
      cw(12'h400, 5'h10, 8'h00, 1'b0);
      cw(12'h400, 5'h00, 8'h02, 1'b0);
      cw(12'h000, 5'h00, 8'h08, 1'b1);
      cw(12'h005, 5'h00, 8'h20, 1'b0);
      cw(12'h100, 5'h00, 8'h11, 1'b0);
      idle(8);
      fin("burst errors and causes");
      // Start flag and address are not defined for a reserved start word
      bp = 1'b1;
      msk.sop = 1'b0;
      msk.addr = 8'h00;
      cw(12'h100, 5'h00, 8'h10, 1'b0);
      dw();
      dw();
      cw(12'h400, 5'h10, 8'h00, 1'b0);
      bp = 1'b0;
      msk = '1;
      idle(8);
      cw(12'h909, 5'h00, 8'h00, 1'b0);
      repeat (7) dw();
      cw(12'hd0a, 5'h12, 8'h00, 1'b1);
      dw();
      dw();
      cw(12'h400, 5'h11, 8'h00, 1'b0);
      idle(8);
      fin("reserved word and parity");
      repeat (80) @(posedge pclk);
      rd(ADDR_LINK, 32'h2);
      apb(1'b0, ADDR_IRQ_STAT, 32'h0);
      chk("lost status", 32'h1, {31'h0, rdv[IRQ_LOST]});
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      #13 idle(20);
      rd(ADDR_LINK, 32'h1);
      chk("words left", 32'h0, 32'(eq.size()));
      chk("causes left", 32'h0, 32'(cq.size()));
      fin("clock loss");
      give_verdict();
   end
endmodule : test_pse_checker
